//--- hdl/isf_top.sv
// Inter-module sync supervision: fault detection, latch and sync output control
//
// Notes on behaviour
// - Refresh spanning cycles raises error 2600H
// - Parameter selects continue or halt on errors
// - Continue mode still latches counts each cycle
// - Completed refresh applied in following cycle
// - Stop mode halts logic on overrun
// - Stop mode still stores host refreshes
// - Partial updates may show during overrun
// - Overrun when period below run plus apply
// - Commands 5us, words 0.42us each, max 30
// - Cycle with no refresh raises 2601H
// - Skip halts logic regardless of mode
// - Refresh after skip applied to state
// - Missing sync pulse raises error 2610H
// - Missing pulse freezes latches and outputs
// - Continue mode resumes updates after pulse returns
// - Stop mode halts logic on sync loss
// - Sync disabled means sync outputs never change
// - Sync outputs show prior cycle result
// - Latches update only at cycle start
`timescale 1ns/1ps
module isf_top #(
	parameter int CMD_W     = isf_pkg::CMD_W,
	parameter int DATA_W    = isf_pkg::DATA_W,
	parameter int CNT_W     = isf_pkg::CNT_W,
	parameter int NUM_CNT   = isf_pkg::NUM_CNT,
	parameter int MAX_WORDS = isf_pkg::MAX_WORDS,
	parameter int OUT_W     = 8
) (
	input  wire logic                       clk,            // 10 MHz module clock
	input  wire logic                       rst_n,          // Async reset, active low
	input  wire logic                       sync_pin,       // Sync pulse from host, async
	input  wire logic                       sync_enable,    // Synchronization selected
	input  wire logic                       stop_on_error,  // 1 stop, 0 continue mode
	input  wire logic [15:0]                period_cyc,     // Expected pulse period
	input  wire logic [5:0]                 words_used,     // Fast-area words assigned
	input  wire logic                       refresh_start,  // Host begins output refresh
	input  wire logic                       refresh_done,   // Host refresh complete, pulse
	input  wire logic [CMD_W-1:0]           general_command_bits, // Commands from host
	input  wire logic [MAX_WORDS*DATA_W-1:0] fast_area_user_data, // Control words from host
	input  wire logic [NUM_CNT*CNT_W-1:0]   live_counts,    // Running counters
	input  wire logic [OUT_W-1:0]           logic_result,   // Hardware logic result
	input  wire logic                       error_clear,    // Clear error and restart, pulse
	output logic [CMD_W-1:0]                applied_cmd,    // Command bits in use
	output logic [MAX_WORDS*DATA_W-1:0]     applied_data,   // Control words in use
	output logic [NUM_CNT*CNT_W-1:0]        latched_count_registers, // Counts at cycle start
	output logic [OUT_W-1:0]                sync_out,       // Sync-aligned outputs
	output logic                            logic_run,      // Hardware logic enabled
	output logic [15:0]                     error_code,     // Latest error code
	output logic                            error_pulse,    // New error, one cycle
	output logic                            apply_too_slow  // Period below apply time
);
	typedef struct packed {
		logic [15:0]                period_cnt;
		logic                       sync_prev;
		logic                       seen_pulse;
		logic                       lost;
		logic                       in_refresh;
		logic                       refresh_seen;
		logic                       pend_apply;
		logic [CMD_W-1:0]           stored_cmd;
		logic [MAX_WORDS*DATA_W-1:0] stored_data;
		logic [CMD_W-1:0]           applied_cmd;
		logic [MAX_WORDS*DATA_W-1:0] applied_data;
		logic [NUM_CNT*CNT_W-1:0]   latch;
		logic [OUT_W-1:0]           prev_result;
		logic [OUT_W-1:0]           sync_out;
		logic                       halted;
		logic [15:0]                err;
		logic                       err_pulse;
	} isf_state_type;
	isf_state_type st, next_st;

	logic sync_lvl;
	logic pulse;
	logic lost_now;
	logic [15:0] apply_cyc;

	// Pin passes the three-stage filter before any edge detection
	isf_sync3 u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (sync_pin),
		.dout  (sync_lvl)
	);

	assign pulse = sync_enable & sync_lvl & ~st.sync_prev;
	assign lost_now = sync_enable & st.seen_pulse & ~pulse &
		(st.period_cnt >= period_cyc + 16'(isf_pkg::MARGIN_CYC));
	assign apply_cyc = 16'(isf_pkg::CMD_APPLY_CYC) + 16'(words_used) * 16'(isf_pkg::WORD_APPLY_CYC);
	// static overrun hazard flag; actual overrun is observed below
	assign apply_too_slow = sync_enable & (period_cyc < apply_cyc);

	// One state update per clock; overrun, skip and latching decided at pulse edges, loss from the period count
	always_comb begin
		next_st = st;
		next_st.err_pulse = 1'b0;
		next_st.sync_prev = sync_lvl;
		if (st.period_cnt != 16'hFFFF) begin
			next_st.period_cnt = st.period_cnt + 16'h0001;
		end
		// host data always stored, even halted
		if (refresh_start) begin
			next_st.in_refresh = 1'b1;
		end
		if (refresh_done) begin
			next_st.in_refresh = 1'b0;
			next_st.stored_cmd = general_command_bits;
			next_st.stored_data = fast_area_user_data;
			next_st.refresh_seen = 1'b1;
			next_st.pend_apply = 1'b1;
		end
		// Clear comes before the error checks, so an error found in the same cycle is kept
		if (error_clear) begin
			next_st.halted = 1'b0;
			next_st.err = isf_pkg::ERR_NONE;
			next_st.lost = 1'b0;
		end
		if (lost_now && !st.lost) begin
			next_st.lost = 1'b1;
			next_st.err = isf_pkg::ERR_SYNC_LOSS;
			next_st.err_pulse = 1'b1;
			if (stop_on_error) begin
				next_st.halted = 1'b1;
			end
		end
		// no pulse, no latch or output change
		if (pulse) begin
			next_st.period_cnt = 16'h0000;
			next_st.seen_pulse = 1'b1;
			next_st.lost = 1'b0;
			next_st.refresh_seen = refresh_done;
			if (st.seen_pulse && st.in_refresh && !refresh_done) begin
				next_st.err = isf_pkg::ERR_OVERRUN;
				next_st.err_pulse = 1'b1;
				if (stop_on_error) begin
					next_st.halted = 1'b1;
				end
			end else if (st.seen_pulse && !st.refresh_seen && !st.in_refresh) begin
				next_st.err = isf_pkg::ERR_SKIP;
				next_st.err_pulse = 1'b1;
				next_st.halted = 1'b1;
			end
			if (st.pend_apply) begin
				next_st.applied_cmd = st.stored_cmd;
				next_st.applied_data = st.stored_data;
				// A refresh landing on this same edge stays pending for the next start
				next_st.pend_apply = refresh_done;
			end
			// latch at cycle start, may hold partial data
			if (!st.halted) begin
				next_st.latch = live_counts;
				next_st.sync_out = st.prev_result;
				next_st.prev_result = logic_result;
			end
		end
		if (!sync_enable) begin
			next_st.seen_pulse = 1'b0;
			next_st.lost = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign applied_cmd = st.applied_cmd;
	assign applied_data = st.applied_data;
	assign latched_count_registers = st.latch;
	assign sync_out = st.sync_out;
	assign logic_run = ~st.halted;
	assign error_code = st.err;
	assign error_pulse = st.err_pulse;

	// Overrun raises its code one cycle after the pulse
	overrun_code_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pulse && st.seen_pulse && st.in_refresh && !refresh_done && !error_clear)
		|=> (error_code == 16'h2600 && error_pulse))
		else $error("overrun code missing");

	// Continue mode keeps running on overrun
	continue_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
		(logic_run && !stop_on_error && pulse && st.in_refresh && !refresh_done)
		|=> logic_run)
		else $error("continue mode halted on overrun");

	// Stop mode halts on overrun
	stop_overrun_a: assert property (@(posedge clk) disable iff (!rst_n)
		(stop_on_error && pulse && st.seen_pulse && st.in_refresh && !refresh_done && !error_clear)
		|=> !logic_run)
		else $error("stop mode failed to halt");

	// Host refresh stored even when halted
	store_halted_a: assert property (@(posedge clk) disable iff (!rst_n)
		(refresh_done && !logic_run) |=> (st.stored_cmd == $past(general_command_bits)))
		else $error("refresh not stored while halted");

	// Skip halts regardless of mode
	skip_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pulse && st.seen_pulse && !st.refresh_seen && !st.in_refresh && !error_clear)
		|=> (!logic_run && error_code == 16'h2601))
		else $error("skip did not halt");

	// Latches frozen without pulse
	latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!pulse |=> $stable(latched_count_registers) && $stable(sync_out))
		else $error("latch changed without pulse");

	// Loss reported with its code
	loss_code_a: assert property (@(posedge clk) disable iff (!rst_n)
		(lost_now && !st.lost && !pulse && !error_clear) |=> (error_code == 16'h2610))
		else $error("sync loss code missing");

	// Sync output carries prior cycle result
	sync_prev_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pulse && logic_run) |=> (sync_out == $past(st.prev_result)))
		else $error("sync output not prior result");

	// Pending data applied at the pulse
	apply_next_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pulse && st.pend_apply) |=> (applied_cmd == $past(st.stored_cmd)))
		else $error("refresh not applied at cycle start");

	// Named steps shared by the properties below

	// A cycle start that finds the host still mid-refresh
	sequence overrun_s;
		pulse && st.seen_pulse && st.in_refresh && !refresh_done;
	endsequence

	// A cycle start after a whole cycle with no refresh at all
	sequence skip_s;
		pulse && st.seen_pulse && !st.refresh_seen && !st.in_refresh;
	endsequence

	// The first cycle past the pulse window
	sequence loss_s;
		lost_now && !st.lost;
	endsequence

	// A cycle start that the running logic acts on
	sequence live_start_s;
		pulse && !st.halted;
	endsequence

	// Continue mode keeps latching through an overrun
	overrun_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
		overrun_s ##0 (!stop_on_error && logic_run)
		|=> (latched_count_registers == $past(live_counts)))
		else $error("latch skipped during overrun");

	// Stored control words reach the applied set at a cycle start
	apply_data_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pulse && st.pend_apply)
		|=> (applied_data == $past(st.stored_data)))
		else $error("control words not applied");

	// A skipped cycle is reported with a fresh error pulse
	skip_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		skip_s
		|=> (error_pulse && error_code == isf_pkg::ERR_SKIP))
		else $error("skip error not reported");

	// A halt holds until it is cleared
	halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!logic_run && !error_clear)
		|=> !logic_run)
		else $error("halt released without clear");

	// Stop mode halts on a lost pulse
	loss_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
		loss_s ##0 stop_on_error
		|=> !logic_run)
		else $error("stop mode kept running on loss");

	// Continue mode keeps running on a lost pulse
	loss_continue_a: assert property (@(posedge clk) disable iff (!rst_n)
		loss_s ##0 (!stop_on_error && logic_run)
		|=> logic_run)
		else $error("continue mode halted on loss");

	// A lost pulse raises a fresh error pulse
	loss_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		loss_s
		|=> error_pulse)
		else $error("loss error pulse missing");

	// A good pulse after a loss ends it and latches again
	resume_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pulse && st.lost && logic_run)
		|=> (!st.lost && latched_count_registers == $past(live_counts)))
		else $error("no resume after loss");

	// With sync off, latches and sync outputs stay put
	disabled_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!sync_enable
		|=> ($stable(sync_out) && $stable(latched_count_registers)))
		else $error("outputs moved with sync off");

	// With sync off, no sync fault can be raised
	disabled_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		!sync_enable
		|=> !error_pulse)
		else $error("error raised with sync off");

	// Halted logic ignores cycle starts
	halted_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pulse && !logic_run)
		|=> ($stable(latched_count_registers) && $stable(sync_out)))
		else $error("halted logic latched");

	// Running logic latches the live counts at every cycle start
	live_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
		live_start_s
		|=> (latched_count_registers == $past(live_counts)))
		else $error("counts not latched at start");

	// No loss is reported inside the expected period
	loss_window_a: assert property (@(posedge clk) disable iff (!rst_n)
		(st.seen_pulse && st.period_cnt < period_cyc && period_cyc < 16'hFF00)
		|=> !(error_pulse && error_code == isf_pkg::ERR_SYNC_LOSS))
		else $error("loss reported inside period");

	// The first cycle start after enabling never counts as a fault
	first_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pulse && !st.seen_pulse)
		|=> !error_pulse)
		else $error("error on first cycle start");

	// Control words are stored and queued even while halted
	halted_store_a: assert property (@(posedge clk) disable iff (!rst_n)
		(refresh_done && !logic_run)
		|=> (st.pend_apply && st.stored_data == $past(fast_area_user_data)))
		else $error("control words lost while halted");

	// A clear with no new fault restarts the logic
	clear_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
		(error_clear && !pulse && !lost_now)
		|=> (logic_run && error_code == isf_pkg::ERR_NONE))
		else $error("clear did not restart");
endmodule : isf_top

//--- hdl/isf_pkg.sv
// Package of constants for the inter-module sync fault handler
package isf_pkg;
	localparam logic [15:0] ERR_NONE      = 16'h0000;
	localparam logic [15:0] ERR_OVERRUN   = 16'h2600;
	localparam logic [15:0] ERR_SKIP      = 16'h2601;
	localparam logic [15:0] ERR_SYNC_LOSS = 16'h2610;
	localparam int CLK_MHZ         = 10;
	localparam int CMD_APPLY_NS    = 5000;
	localparam int WORD_APPLY_NS   = 420;
	localparam int MAX_WORDS       = 30;
	// Apply times in cycles, rounded up as least times
	localparam int CMD_APPLY_CYC   = (CMD_APPLY_NS * CLK_MHZ + 999) / 1000;
	localparam int WORD_APPLY_CYC  = (WORD_APPLY_NS * CLK_MHZ + 999) / 1000;
	localparam int PERIOD_DEF_CYC  = 1000;
	localparam int MARGIN_CYC      = 4;
	localparam int CMD_W           = 16;
	localparam int DATA_W          = 16;
	localparam int CNT_W           = 32;
	localparam int NUM_CNT         = 8;
endpackage : isf_pkg

//--- hdl/isf_sync3.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module isf_sync3 (
	input  wire logic clk,    // Module clock
	input  wire logic rst_n,  // Async reset, active low
	input  wire logic din,    // Asynchronous pin level
	output logic      dout    // Filtered level
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} isf_sync_type;
	isf_sync_type st, next_st;

	// Stage one feeds only stage two; the filter looks at stages two and three
	always_comb begin
		next_st = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (st.s2 == st.s3) begin
			next_st.q = st.s3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign dout = st.q;
endmodule : isf_sync3

//--- verif/isf_host.sv
// Host model: sync pulse source and refresh master
`timescale 1ns/1ps
module isf_host (
	input  wire logic        clk,                 // Clock
	input  wire logic        rst_n,               // Reset, active low
	input  wire logic        drop,                // Withhold pulses
	input  wire logic [1:0]  mode,                // 0 full, 1 none, 2 late
	input  wire logic [15:0] per,                 // Period in cycles
	input  wire logic [15:0] cmd,                 // Next command word
	output logic             sync_pin,            // Sync pulse
	output logic             refresh_start,       // Refresh begins
	output logic             refresh_done,        // Refresh complete
	output logic [15:0]      general_command_bits // Command word
);
	logic [15:0] cnt;
	// Refresh runs at fixed offsets after each pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 16'h0000;
			sync_pin <= 1'b0;
			refresh_start <= 1'b0;
			refresh_done <= 1'b0;
			general_command_bits <= 16'h0000;
		end else begin
			cnt <= (cnt >= per - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
			sync_pin <= !drop && cnt < 16'h0004;
			refresh_start <= cnt == 16'h0014 && mode != 2'h1;
			refresh_done <= cnt == 16'h001E && mode == 2'h0;
			// Toggles outside done so stale data never passes
			general_command_bits <= (cnt == 16'h001E) ? cmd : ~general_command_bits;
		end
	end
endmodule : isf_host

//--- verif/isf_top_tb.sv
// Self-checking bench for the sync fault handler
`timescale 1ns/1ps
module isf_top_tb;
	logic         clk, rst_n, sync_pin, sync_enable, stop_on_error, drop, error_clear;
	logic         refresh_start, refresh_done, logic_run, error_pulse, apply_too_slow;
	logic [1:0]   mode;
	logic [5:0]   words_used;
	logic [15:0]  period_cyc, cmd, general_command_bits, applied_cmd, error_code;
	logic [479:0] fast_area_user_data, applied_data;
	logic [255:0] live_counts, latched_count_registers, old_l;
	logic [7:0]   logic_result, sync_out, lr_prev;
	int           n_errors, checks_done, seed;
	logic [15:0]  exp_q[$];

	isf_top isf_top_i (.clk, .rst_n, .sync_pin, .sync_enable, .stop_on_error, .period_cyc, .words_used,
		.refresh_start, .refresh_done, .general_command_bits, .fast_area_user_data, .live_counts,
		.logic_result, .error_clear, .applied_cmd, .applied_data, .latched_count_registers, .sync_out,
		.logic_run, .error_code, .error_pulse, .apply_too_slow);
	isf_host isf_host_i (.clk, .rst_n, .drop, .mode, .per(period_cyc), .cmd, .sync_pin, .refresh_start,
		.refresh_done, .general_command_bits);
	assign fast_area_user_data = {30{general_command_bits}};

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task check(input string nm, input logic [479:0] seen, input logic [479:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task conclude;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	// Each error pulse takes the oldest expected code
	always @(negedge clk) begin
		if (error_pulse === 1'b1) begin
			if (exp_q.size() == 0) check("error_code", error_code, 16'h0000);
			else check("error_code", error_code, exp_q.pop_front());
		end
	end

	// Waits for a pulse, checks what it applied, then stages the next cycle
	task step(input logic [2:0] m, input logic [1:0] hm);
		int k;
		k = 0;
		while (sync_pin !== 1'b1 && k < 1000) begin
			@(negedge clk);
			k++;
		end
		if (k == 1000) begin
			n_errors++;
			conclude();
		end
		repeat (15) @(negedge clk);
		if (m[2]) check("applied_cmd", applied_cmd, cmd);
		if (m[2]) check("applied_data", applied_data, {30{cmd}});
		if (m[1]) check("latched", latched_count_registers, live_counts);
		if (m[0]) check("sync_out", sync_out, lr_prev);
		lr_prev = logic_result;
		old_l = live_counts; // Value this start latched
		cmd = 16'($random(seed));
		live_counts = {8{$random(seed)}};
		logic_result = 8'($random(seed));
		mode = hm;
	endtask : step

	task clear;
		error_clear = 1'b1;
		@(negedge clk);
		error_clear = 1'b0;
		@(negedge clk);
		check("logic_run", logic_run, 1'b1);
		check("error_code", error_code, 16'h0000);
	endtask : clear

	// Withholds one pulse; counts must freeze until it returns
	task lose;
		exp_q.push_back(16'h2610);
		drop = 1'b1;
		live_counts = {8{$random(seed)}};
		repeat (300) @(negedge clk);
		check("latched", latched_count_registers, old_l);
		check("logic_run", logic_run, !stop_on_error);
		drop = 1'b0;
		step({1'b1, !stop_on_error, 1'b0}, 2'h0);
	endtask : lose

	initial begin
		seed = 62427;
		rst_n = 1'b0;
		{sync_enable, stop_on_error, error_clear, n_errors, checks_done} = '0;
		drop = 1'b1;
		mode = 2'h0;
		cmd = 16'h0000;
		lr_prev = 8'h00;
		period_cyc = 16'h00C8;
		words_used = 6'h0A;
		live_counts = {8{$random(seed)}};
		logic_result = 8'($random(seed));
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		check("logic_run", logic_run, 1'b1);
		// Apply-time threshold at its exact boundary; the flag only speaks while sync is selected
		sync_enable = 1'b1;
		for (int w = 0; w <= 30; w += 10) begin
			@(negedge clk);
			words_used = 6'(w);
			period_cyc = 16'(50 + 5 * w);
			#1 check("apply_too_slow", apply_too_slow, 1'b0);
			@(negedge clk);
			period_cyc = 16'(49 + 5 * w);
			#1 check("apply_too_slow", apply_too_slow, 1'b1);
		end
		@(negedge clk);
		sync_enable = 1'b0;
		period_cyc = 16'h00C8;
		words_used = 6'h0A;
		repeat (600) @(negedge clk);
		check("sync_out", sync_out, 8'h00);
		sync_enable = 1'b1;
		drop = 1'b0;
		step(3'b000, 2'h0);
		repeat (3) step(3'b111, 2'h0);
		exp_q.push_back(16'h2601);
		step(3'b111, 2'h1);
		step(3'b000, 2'h0);
		check("logic_run", logic_run, 1'b0);
		step(3'b100, 2'h0);
		clear();
		step(3'b110, 2'h0);
		exp_q.push_back(16'h2600);
		step(3'b111, 2'h2);
		step(3'b010, 2'h0);
		check("logic_run", logic_run, 1'b1);
		step(3'b111, 2'h0);
		stop_on_error = 1'b1;
		exp_q.push_back(16'h2600);
		step(3'b111, 2'h2);
		step(3'b000, 2'h0);
		check("logic_run", logic_run, 1'b0);
		step(3'b100, 2'h0);
		clear();
		step(3'b110, 2'h0);
		stop_on_error = 1'b0;
		lose();
		step(3'b111, 2'h0);
		stop_on_error = 1'b1;
		lose();
		clear();
		step(3'b110, 2'h0);
		check("pending", 32'(exp_q.size()), 32'h0);
		conclude();
	end
endmodule : isf_top_tb
